// ==== verilog/taw_pkg.sv ====
// Constants, register pointers and carrier types of the thermal alarm window logic
package taw_pkg;

   // Register pointers as seen by the serial protocol engine
   localparam logic [7:0] PTR_CONFIG = 8'h01; // Configuration word
   localparam logic [7:0] PTR_UPPER = 8'h02; // Upper window limit
   localparam logic [7:0] PTR_LOWER = 8'h03; // Lower window limit
   localparam logic [7:0] PTR_CRIT = 8'h04; // Critical limit
   localparam logic [7:0] PTR_TEMP = 8'h05; // Temperature word

   // Values after reset
   localparam logic [15:0] CFG_RESET = 16'h0000; // Disabled, comparator, active low
   localparam logic [15:0] LIMIT_RESET = 16'h0000; // All limits at zero degrees
   localparam logic [12:0] TEMP_RESET = 13'h0000; // Temperature before first conversion

   // Temperature field width and status bit positions in the temperature word
   localparam int TEMP_W = 13; // Signed, 1/16 degree per count
   localparam int TW_CRIT = 15; // At or above critical limit
   localparam int TW_ABOVE = 14; // Above window
   localparam int TW_BELOW = 13; // Below window

   // Hysteresis in 1/16 degree counts: 0, 1.5, 3 and 6 degrees
   localparam logic [7:0] HYS_0 = 8'h00;
   localparam logic [7:0] HYS_1 = 8'h18;
   localparam logic [7:0] HYS_2 = 8'h30;
   localparam logic [7:0] HYS_3 = 8'h60;

   // Timing: clock period and conversion period in their own units
   localparam int CLK_PERIOD_NS = 20; // 50 MHz
   localparam int CONV_PERIOD_MS = 125; // Longest conversion period
   // Longest time, so rounded down
   localparam int CONV_PERIOD_CYC = (CONV_PERIOD_MS * 1000000) / CLK_PERIOD_NS;
   localparam int CONV_CNT_W = 23; // Holds 6,250,000

   // Register access from the serial protocol engine
   typedef struct packed {
      logic wr; // One-cycle write strobe
      logic rd; // One-cycle strobe at start of a read transfer
      logic [7:0] ptr; // Register pointer
      logic [15:0] wdata; // Write data, both bytes assembled
   } taw_req_t;

   // Configuration word fields, bit 15 down to bit 0
   typedef struct packed {
      logic [4:0] spare; // Reads as zero
      logic [1:0] hys; // Hysteresis select
      logic shutdown; // Stops conversions, alarm held
      logic critLock; // Critical limit write lock
      logic winLock; // Window limits write lock
      logic clear; // Write 1 clears the interrupt alarm
      logic status; // Alarm status, read only
      logic enable; // Alarm output enable
      logic critOnly; // Critical-only banding
      logic polarity; // 1 = active high
      logic intMode; // 1 = interrupt mode
   } taw_cfg_t;

endpackage : taw_pkg

// ==== verilog/taw_band_cmp.sv ====
// One limit comparator with hysteresis, updated on each evaluation strobe
`timescale 1ns/1ps
module taw_band_cmp #(
   parameter bit ABOVE = 1'b1, // 1 = flags above limit, 0 = below
   parameter bit INCL = 1'b0 // Set on equality too (above only)
) (
   input wire logic clk, // System clock
   input wire logic rst, // Synchronous reset, active high
   input wire logic evalStb, // Evaluate on this cycle
   input wire logic [12:0] temp, // Latched temperature
   input wire logic [12:0] limit, // Limit value
   input wire logic [7:0] hys, // Hysteresis counts
   output logic flag // Condition flag
);
   logic signed [14:0] tempS; // Sign-extended so limit +- hys never wraps
   logic signed [14:0] limS; // Sign-extended limit
   logic signed [14:0] hysS; // Positive hysteresis
   logic setCond; // Condition starts
   logic clrCond; // Condition ends
   logic next_flag; // Flag after this cycle

   assign tempS = {{2{temp[12]}}, temp};
   assign limS = {{2{limit[12]}}, limit};
   assign hysS = {7'h00, hys};

   // Start and end thresholds; ending needs the hysteresis margin
   always_comb begin
      next_flag = flag;
      if (ABOVE) begin
         setCond = INCL ? (tempS >= limS) : (tempS > limS);
         clrCond = INCL ? (tempS < limS - hysS) : (tempS <= limS - hysS);
      end else begin
         setCond = tempS < limS;
         clrCond = tempS >= limS + hysS;
      end
      if (evalStb) begin
         next_flag = flag ? !clrCond : setCond;
      end
   end

   // Flag register
   always_ff @(posedge clk) begin
      if (rst) begin
         flag <= 1'b0;
      end else begin
         flag <= next_flag;
      end
   end

   band_fall_a: assert property (@(posedge clk) disable iff (rst)
      $fell(flag) |-> $past(evalStb && clrCond))
      else $error("band flag fell without hysteresis margin");

endmodule : taw_band_cmp

// ==== verilog/taw_conv_timer.sv ====
// Conversion period timer, one tick per completed conversion
`timescale 1ns/1ps
module taw_conv_timer #(
   parameter int PERIOD = taw_pkg::CONV_PERIOD_CYC // Cycles per conversion
) (
   input wire logic clk, // System clock
   input wire logic rst, // Synchronous reset, active high
   output logic tick // One-cycle pulse per period
);
   localparam int W = taw_pkg::CONV_CNT_W;
   localparam logic [W-1:0] LAST = W'(PERIOD - 1); // Final count
   logic [W-1:0] count; // Cycles into this period

   always_ff @(posedge clk) begin
      if (rst) begin
         count <= '0;
         tick <= 1'b0;
      end else if (count == LAST) begin
         count <= '0;
         tick <= 1'b1;
      end else begin
         count <= count + 1'b1;
         tick <= 1'b0;
      end
   end

   period_bound_a: assert property (@(posedge clk) disable iff (rst)
      count <= LAST)
      else $error("conversion counter overran its period");

endmodule : taw_conv_timer

// ==== verilog/taw_alarm.sv ====
// Thermal alarm window logic: limits, hysteresis, alarm pin and read snapshot
//
// How it works
// - Comparator mode alarms outside the window
// - Register traffic never moves comparator alarm
// - Comparator alarm holds until back inside
// - Enabled interrupt alarm triggers on each window crossing
// - Interrupt alarm holds until clear bit
// - Alert response win also clears interrupt alarm
// - Critical alarm ignores clears, ends with hysteresis
// - Above critical forces comparator behaviour
// - Critical exit drops interrupt alarm at once
// - Critical-only mode ignores window limits
// - Temperature word carries three status flags
// - Conditions end only past hysteresis margin
// - New limits wait for fresh conversion
// - Conversions run at least eight per second
// - Read returns latest completed conversion
// - Read transfer never torn by conversion
// - Alarm pin floats until enabled
// - Polarity bit selects active level
// - Config selects mode, banding and hysteresis
`timescale 1ns/1ps
module taw_alarm #(
   parameter int CONV_CYCLES = taw_pkg::CONV_PERIOD_CYC // Shorten for simulation
) (
   input wire logic clk, // System clock, 50 MHz
   input wire logic rst, // Synchronous reset, active high
   input wire taw_pkg::taw_req_t busReq, // Register access from protocol engine
   input wire logic araWon, // Pulse: alert response won
   input wire logic [12:0] adcSample, // Converter result, valid at tick
   output logic [15:0] regRdata, // Read word, held for the transfer
   output logic alarmOut, // Alarm pin output value
   output logic alarmOe, // Alarm pin output enable
   output logic convStart // Pulse: result taken, next conversion runs
);

   // Configuration and limit registers
   taw_pkg::taw_cfg_t cfg; // Configuration word
   taw_pkg::taw_cfg_t newCfg; // Incoming configuration write
   logic [15:0] upperLim; // Upper window limit
   logic [15:0] lowerLim; // Lower window limit
   logic [15:0] critLim; // Critical limit
   // Access decode
   logic wrCfg; // Config write
   logic wrUpper; // Upper limit write
   logic wrLower; // Lower limit write
   logic wrCrit; // Critical limit write
   logic limitWrite; // Any accepted limit write
   logic clearPulse; // Clear bit written as 1
   // Conversion and evaluation
   logic convTick; // Conversion completes
   logic [12:0] tempVal; // Last completed conversion
   logic evalStb; // Compare flags this cycle
   logic skipEval; // Next conversion predates a limit write
   logic [7:0] hysCnt; // Hysteresis in counts
   // Flags and alarm state
   logic critF; // At or above critical
   logic aboveF; // Above window
   logic belowF; // Below window
   logic prevOutside; // Outside state one cycle ago
   logic prevCrit; // Critical state one cycle ago
   logic crossing; // Window entered or left
   logic critExit; // Critical condition ended
   logic setInt; // Interrupt alarm triggers
   logic intLatch; // Interrupt alarm pending
   logic alarmActive; // Alarm asserted, before polarity
   logic pinLevel; // Logical pin level
   assign newCfg = taw_pkg::taw_cfg_t'(busReq.wdata);
   assign wrCfg = busReq.wr && (busReq.ptr == taw_pkg::PTR_CONFIG);
   assign wrUpper = busReq.wr && (busReq.ptr == taw_pkg::PTR_UPPER);
   assign wrLower = busReq.wr && (busReq.ptr == taw_pkg::PTR_LOWER);
   assign wrCrit = busReq.wr && (busReq.ptr == taw_pkg::PTR_CRIT);
   assign clearPulse = wrCfg && newCfg.clear;
   // Locked limits are not rewritten, so they never restart the freshness wait
   assign limitWrite = ((wrUpper || wrLower) && !cfg.winLock) || (wrCrit && !cfg.critLock);

   // Configuration register
   always_ff @(posedge clk) begin
      if (rst) begin
         cfg <= taw_pkg::taw_cfg_t'(taw_pkg::CFG_RESET);
      end else if (wrCfg) begin
         // mode and banding fields
         // Once enabled, mode and banding are frozen; software must disable first
         cfg.intMode <= cfg.enable ? cfg.intMode : newCfg.intMode;
         cfg.critOnly <= cfg.enable ? cfg.critOnly : newCfg.critOnly;
         cfg.polarity <= newCfg.polarity;
         cfg.enable <= newCfg.enable;
         cfg.winLock <= newCfg.winLock;
         cfg.critLock <= newCfg.critLock;
         cfg.shutdown <= newCfg.shutdown;
         cfg.hys <= newCfg.hys;
         // Status, clear and spare bits are never stored; they keep their reset zero
      end
   end

   // Window limit registers
   always_ff @(posedge clk) begin
      if (rst) begin
         upperLim <= taw_pkg::LIMIT_RESET;
         lowerLim <= taw_pkg::LIMIT_RESET;
      end else if (!cfg.winLock) begin
         if (wrUpper) begin
            upperLim <= busReq.wdata;
         end
         if (wrLower) begin
            lowerLim <= busReq.wdata;
         end
      end
   end

   // Critical limit register
   always_ff @(posedge clk) begin
      if (rst) begin
         critLim <= taw_pkg::LIMIT_RESET;
      end else if (wrCrit && !cfg.critLock) begin
         critLim <= busReq.wdata;
      end
   end

   // Conversion period source
   taw_conv_timer #(
      .PERIOD(CONV_CYCLES)
   ) u_timer (
      .clk(clk),
      .rst(rst),
      .tick(convTick)
   );

   // Latch each completed conversion; shutdown freezes result and flags
   always_ff @(posedge clk) begin
      if (rst) begin
         tempVal <= taw_pkg::TEMP_RESET;
         convStart <= 1'b0;
      end else begin
         if (convTick && !cfg.shutdown) begin
            tempVal <= adcSample;
         end
         convStart <= convTick && !cfg.shutdown;
      end
   end

   // skip conversion begun before limit write
   always_ff @(posedge clk) begin
      if (rst) begin
         skipEval <= 1'b0;
      end else if (limitWrite) begin
         // Set wins over the tick that would clear it
         skipEval <= 1'b1;
      end else if (convTick) begin
         skipEval <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         evalStb <= 1'b0;
      end else begin
         evalStb <= convTick && !cfg.shutdown && !skipEval && !limitWrite;
      end
   end

   // hysteresis select, code 3 is the widest margin
   assign hysCnt = cfg.hys[1] ? (cfg.hys[0] ? taw_pkg::HYS_3 : taw_pkg::HYS_2)
      : (cfg.hys[0] ? taw_pkg::HYS_1 : taw_pkg::HYS_0);

   // Critical condition starts at equality
   taw_band_cmp #(
      .ABOVE(1'b1),
      .INCL(1'b1)
   ) u_crit (
      .clk(clk),
      .rst(rst),
      .evalStb(evalStb),
      .temp(tempVal),
      .limit(critLim[12:0]),
      .hys(hysCnt),
      .flag(critF)
   );

   // Above-window condition
   taw_band_cmp #(
      .ABOVE(1'b1),
      .INCL(1'b0)
   ) u_upper (
      .clk(clk),
      .rst(rst),
      .evalStb(evalStb),
      .temp(tempVal),
      .limit(upperLim[12:0]),
      .hys(hysCnt),
      .flag(aboveF)
   );

   // Below-window condition
   taw_band_cmp #(
      .ABOVE(1'b0),
      .INCL(1'b0)
   ) u_lower (
      .clk(clk),
      .rst(rst),
      .evalStb(evalStb),
      .temp(tempVal),
      .limit(lowerLim[12:0]),
      .hys(hysCnt),
      .flag(belowF)
   );

   // Previous states for crossing detection
   always_ff @(posedge clk) begin
      if (rst) begin
         prevOutside <= 1'b0;
         prevCrit <= 1'b0;
      end else begin
         prevOutside <= aboveF || belowF;
         prevCrit <= critF;
      end
   end

   assign crossing = (aboveF || belowF) != prevOutside;
   assign critExit = prevCrit && !critF;
   assign setInt = crossing && cfg.enable && cfg.intMode && !cfg.critOnly;

   always_ff @(posedge clk) begin
      if (rst) begin
         intLatch <= 1'b0;
      end else if (setInt) begin
         // A crossing in the clearing cycle is kept
         intLatch <= 1'b1;
      end else if (clearPulse || araWon || critExit) begin
         // critical exit drops it at once
         intLatch <= 1'b0;
      end
   end

   // Alarm decision; critical outranks the mode selection
   always_comb begin
      if (cfg.critOnly) begin
         alarmActive = critF;
      end else if (critF) begin
         alarmActive = 1'b1;
      end else if (cfg.intMode) begin
         alarmActive = intLatch;
      end else begin
         alarmActive = aboveF || belowF;
      end
   end

   assign pinLevel = cfg.polarity ? alarmActive : !alarmActive;

   // Open-drain pin: only ever pulls low
   always_ff @(posedge clk) begin
      if (rst) begin
         alarmOe <= 1'b0;
         alarmOut <= 1'b0;
      end else begin
         alarmOe <= cfg.enable && !pinLevel;
         alarmOut <= 1'b0;
      end
   end

   // read word captured once per transfer
   // Both bytes come from this one capture, so a tick mid-transfer cannot tear it
   always_ff @(posedge clk) begin
      if (rst) begin
         regRdata <= 16'h0000;
      end else if (busReq.rd) begin
         case (busReq.ptr)
            taw_pkg::PTR_CONFIG: begin
               regRdata <= {cfg.spare, cfg.hys, cfg.shutdown, cfg.critLock, cfg.winLock,
                  1'b0, alarmActive, cfg.enable, cfg.critOnly, cfg.polarity, cfg.intMode};
            end
            taw_pkg::PTR_UPPER: regRdata <= upperLim;
            taw_pkg::PTR_LOWER: regRdata <= lowerLim;
            taw_pkg::PTR_CRIT: regRdata <= critLim;
            taw_pkg::PTR_TEMP: begin
               regRdata <= {critF, aboveF, belowF, tempVal};
            end
            default: regRdata <= 16'h0000;
         endcase
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   pin_disabled_a: assert property (!cfg.enable |=> !alarmOe)
      else $error("alarm pin driven while disabled");
   pol_low_a: assert property (cfg.enable && !cfg.polarity && alarmActive |=> alarmOe)
      else $error("active-low alarm not pulled low");
   pol_high_a: assert property (cfg.enable && cfg.polarity && alarmActive |=> !alarmOe)
      else $error("active-high alarm pulled low while asserted");
   window_cmp_a: assert property (!cfg.intMode && !cfg.critOnly && (aboveF || belowF)
      |-> alarmActive)
      else $error("comparator alarm missing outside window");
   window_release_a: assert property (!cfg.intMode && !cfg.critOnly && !critF
      && !aboveF && !belowF |-> !alarmActive)
      else $error("comparator alarm stuck inside window");
   flags_static_a: assert property (!evalStb |=> $stable({critF, aboveF, belowF}))
      else $error("flags changed without a conversion");
   crit_override_a: assert property (critF && !cfg.critOnly |-> alarmActive)
      else $error("critical condition not alarmed");
   crit_only_a: assert property (cfg.critOnly |-> alarmActive == critF)
      else $error("critical-only alarm follows window");
   cross_latch_a: assert property (setInt |=> intLatch)
      else $error("window crossing lost");
   int_hold_a: assert property (intLatch && !clearPulse && !araWon && !critExit
      |=> intLatch)
      else $error("interrupt alarm dropped without clear");
   ara_clear_a: assert property (araWon && !setInt |=> !intLatch)
      else $error("alert response did not clear alarm");
   crit_exit_a: assert property (critExit && !setInt |=> !intLatch)
      else $error("alarm held after critical exit");
   // limit write blocks the next evaluation
   fresh_conv_a: assert property ((limitWrite || skipEval) && convTick |=> !evalStb)
      else $error("stale conversion compared with new limits");
   eval_tick_a: assert property (evalStb |-> $past(convTick))
      else $error("evaluation without a conversion");
   hys_map_a: assert property (cfg.hys == 2'b11 |-> hysCnt == taw_pkg::HYS_3)
      else $error("hysteresis select misdecoded");
   status_bits_a: assert property (busReq.rd && busReq.ptr == taw_pkg::PTR_TEMP
      |=> regRdata[15:13] == $past({critF, aboveF, belowF}))
      else $error("temperature status bits wrong");
   read_hold_a: assert property (!busReq.rd |=> $stable(regRdata))
      else $error("read word changed mid-transfer");

   int_alarm_c: cover property (setInt ##1 intLatch);
   crit_alarm_c: cover property ($rose(critF) && cfg.enable);
   ara_clear_c: cover property (intLatch && araWon);
   tick_in_read_c: cover property (busReq.rd ##1 convTick);

endmodule : taw_alarm

// ==== testbench/taw_far_model.sv ====
// Far side: converter sample source and pulled-up alarm pin
`timescale 1ns/1ps
module taw_far_model (
   input wire logic clk, // System clock
   input wire logic rst, // Synchronous reset
   input wire logic convStart, // Previous sample taken
   input wire logic [12:0] tempReq, // Next temperature wanted
   input wire logic alarmOut, // Pin value
   input wire logic alarmOe, // Pin drive enable
   output logic [12:0] adcSample, // Sample offered
   output wire logic pinLevel // Resolved pin level
);
   // New sample only once the last was taken, so a period never sees two values
   always_ff @(posedge clk) begin
      if (rst) begin
         adcSample <= 13'h0000; // Cold start
      end else if (convStart) begin
         adcSample <= tempReq; // Next result
      end
   end
   // Released pin goes to the pull-up level, never the last driven value
   assign pinLevel = alarmOe ? alarmOut : 1'b1;
endmodule : taw_far_model

// ==== testbench/tb_top.sv ====
// Self-checking bench of the thermal alarm window logic
`timescale 1ns/1ps
module tb_top;
   localparam int CONV = 64; // Short period keeps the run small
   localparam logic [7:0] CFG = taw_pkg::PTR_CONFIG; // Pointer aliases
   localparam logic [7:0] TMP = taw_pkg::PTR_TEMP;
   logic clk; // System clock
   logic rst; // Synchronous reset
   taw_pkg::taw_req_t busReq; // Register access
   logic araWon; // Alert response won
   logic [12:0] adcSample; // Sample from far side
   logic [15:0] regRdata; // Read word
   logic alarmOut; // Pin value
   logic alarmOe; // Pin enable
   logic convStart; // Result taken
   logic [12:0] tempReq; // Wanted temperature
   logic pinLevel; // Resolved pin
   logic [15:0] rdVal; // Last read word
   logic signed [12:0] upperV, lowerV, critV, rt; // Limits and test temperature
   logic [12:0] corner [4]; // Window edges
   integer seed; // Random seed
   int fails; // Mismatches
   int comparisons; // Checks made
   int i; // Loop index

   // Clock
   initial clk = 1'b0;
   always #10 clk = ~clk;

   taw_alarm #(.CONV_CYCLES(CONV)) dut_u (.clk(clk), .rst(rst), .busReq(busReq),
      .araWon(araWon), .adcSample(adcSample), .regRdata(regRdata), .alarmOut(alarmOut),
      .alarmOe(alarmOe), .convStart(convStart));
   taw_far_model far_u (.clk(clk), .rst(rst), .convStart(convStart), .tempReq(tempReq),
      .alarmOut(alarmOut), .alarmOe(alarmOe), .adcSample(adcSample), .pinLevel(pinLevel));

   // Temperature word with hysteresis zero: flags follow the limits directly
   function automatic logic [15:0] expWord(input logic signed [12:0] t);
      return {t >= critV, t > upperV, t < lowerV, t};
   endfunction : expWord

   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic pinIs(input logic e);
      chk("pin", {15'h0000, pinLevel}, {15'h0000, e});
   endtask : pinIs

   task automatic wr(input logic [7:0] p, input logic [15:0] d);
      @(posedge clk);
      busReq <= {1'b1, 1'b0, p, d};
      @(posedge clk);
      busReq.wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] p);
      @(posedge clk);
      busReq <= {1'b0, 1'b1, p, 16'h0000};
      @(posedge clk);
      busReq.rd <= 1'b0;
      @(negedge clk);
      rdVal = regRdata;
   endtask : rd

   // Count conversions with a bound, then let the alarm path settle
   task automatic waitConv(input int n);
      int k;
      for (int j = 0; j < n; j++) begin
         k = 0;
         @(negedge clk);
         while (convStart !== 1'b1 && k < 4 * CONV) begin
            @(negedge clk);
            k++;
         end
         if (k >= 4 * CONV) fails++;
         // Results follow each other exactly one period apart
         if (j > 0) chk("period", 16'(k + 1), 16'(CONV));
      end
      repeat (6) @(negedge clk);
   endtask : waitConv

   task automatic setT(input logic [12:0] t);
      @(posedge clk);
      tempReq <= t;
      waitConv(2);
   endtask : setT

   task automatic pulseAra();
      @(posedge clk);
      araWon <= 1'b1;
      @(posedge clk);
      araWon <= 1'b0;
      repeat (5) @(negedge clk);
   endtask : pulseAra

   task automatic test_done();
      $display("Comparisons %0d mismatches %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : test_done

   // Watchdog well beyond the expected run length
   initial begin
      #1000000;
      fails++;
      test_done();
   end

   initial begin
      seed = 32'hdb84;
      rst = 1'b1;
      busReq = '0;
      araWon = 1'b0;
      tempReq = 13'h0000;
      corner = '{13'h0550, 13'h1f40, 13'h0551, 13'h1f3f};
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      pinIs(1'b1);
      rd(CFG);
      chk("config reset", rdVal, taw_pkg::CFG_RESET);
      // upper above lower, critical above upper
      upperV = 13'h0550;
      lowerV = 13'h1f40;
      critV = 13'h05f0;
      wr(taw_pkg::PTR_UPPER, 16'h0550);
      wr(taw_pkg::PTR_LOWER, 16'h1f40);
      wr(taw_pkg::PTR_CRIT, 16'h05f0);
      rd(taw_pkg::PTR_UPPER);
      chk("upper limit", rdVal, 16'h0550);
      rd(8'h07);
      chk("unmapped", rdVal, 16'h0000);
      setT(13'h0600);
      pinIs(1'b1);
      rd(TMP);
      chk("temp word", rdVal, expWord(13'h0600));
      // enable after a full period, wait, then look
      wr(CFG, 16'h0008);
      repeat (1000) @(negedge clk);
      pinIs(1'b0);
      // Edges of the window, then random temperatures, comparator mode
      for (i = 0; i < 16; i++) begin
         rt = (i < 4) ? corner[i] : 13'(($random(seed) & 32'hfff) - 32'h300);
         setT(rt);
         pinIs(~(rt > upperV || rt < lowerV));
         rd(TMP);
         chk("temp word", rdVal, expWord(rt));
      end
      setT(13'h0560);
      wr(CFG, 16'h0028);
      rd(CFG);
      pinIs(1'b0);
      setT(13'h0400);
      // limit written just after a conversion is not used on the next one
      wr(taw_pkg::PTR_UPPER, 16'h0300);
      upperV = 13'h0300;
      waitConv(1);
      pinIs(1'b1);
      waitConv(1);
      pinIs(1'b0);
      wr(taw_pkg::PTR_UPPER, 16'h0550);
      upperV = 13'h0550;
      waitConv(2);
      pinIs(1'b1);
      // hysteresis of 24 counts on the upper limit
      wr(CFG, 16'h0208);
      setT(13'h0560);
      pinIs(1'b0);
      setT(13'h0540);
      pinIs(1'b0);
      setT(13'h0538);
      pinIs(1'b1);
      // Widest hysteresis code: 96 counts below the upper limit
      wr(CFG, 16'h0608);
      setT(13'h0560);
      setT(13'h04f8);
      pinIs(1'b0);
      setT(13'h04f0);
      pinIs(1'b1);
      wr(CFG, 16'h000a);
      repeat (6) @(negedge clk);
      pinIs(1'b0);
      setT(13'h0560);
      pinIs(1'b1);
      setT(13'h0400);
      // Interrupt mode: disable first, mode bits are frozen while enabled
      wr(CFG, 16'h0000);
      wr(CFG, 16'h0009);
      rd(CFG);
      chk("config", rdVal, 16'h0009);
      setT(13'h0560);
      pinIs(1'b0);
      wr(CFG, 16'h0029);
      repeat (5) @(negedge clk);
      pinIs(1'b1);
      setT(13'h0400);
      pinIs(1'b0);
      pulseAra();
      pinIs(1'b1);
      setT(13'h0560);
      wr(CFG, 16'h0029);
      setT(13'h0600);
      pinIs(1'b0);
      wr(CFG, 16'h0029);
      pulseAra();
      pinIs(1'b0);
      setT(13'h05e0);
      pinIs(1'b1);
      // Critical-only banding
      wr(CFG, 16'h0000);
      wr(CFG, 16'h000c);
      for (i = 0; i < 4; i++) begin
         rt = (i == 0) ? 13'h0560 : (i == 1) ? 13'h1e00 : (i == 2) ? 13'h0600 : 13'h0400;
         setT(rt);
         pinIs(rt < critV);
      end
      // word stands across a conversion, next read is fresh
      rd(TMP);
      setT(13'h0470);
      chk("held word", regRdata, expWord(13'h0400));
      rd(TMP);
      chk("new word", rdVal, expWord(13'h0470));
      test_done();
   end
endmodule : tb_top
